// ==== scgr_regs.sv ====
`timescale 1ns/1ps
`include "scgr_cfg.svh"


module scgr_regs
#(
	parameter logic [15:0] SUBSYSTEM_VENDOR_IDENTIFIER_RST = 16'h5A3C, // Arbitrary value
	parameter logic [15:0] SUBSYSTEM_DEVICE_IDENTIFIER_RST = 16'h3C5A // Arbitrary value
)
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic upstream,
	input wire logic cfg_valid,
	input wire scgr_pkg::scgr_access_s cfg_req,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	input wire logic load_valid,
	input wire scgr_pkg::scgr_access_s load_req,
	input wire scgr_pkg::scgr_opmode_s opmode_pins,
	input wire logic clock_buffer_powerdown_strap,
	output logic [`SCGR_CBUF_PAIRS-1:0] reference_clock_out_pair,
	input wire logic [`SCGR_GPIO_PINS-1:0] gpio_in,
	output logic [`SCGR_GPIO_PINS-1:0] gpio_out,
	output logic [`SCGR_GPIO_PINS-1:0] gpio_oe
);

	localparam int SW = `SCGR_OPMODE_W + 1;

	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [SW-1:0] sync3;
	logic [SW-1:0] straps;
	logic [SW-1:0] next_straps;
	logic [`SCGR_CBUF_W-1:0] cbuf;
	logic [`SCGR_CBUF_W-1:0] next_cbuf;
	logic [15:0] subsystem_vendor_identifier;
	logic [15:0] next_subsystem_vendor_identifier;
	logic [15:0] subsystem_device_identifier;
	logic [15:0] next_subsystem_device_identifier;
	logic [`SCGR_CBUF_PAIRS-1:0] next_refclk;
	logic next_ack;
	logic [31:0] next_rdata;
	logic [15:0] gpio_word;
	logic gpio_wr;
	logic strap_owned;
	logic next_strap_owned;
	logic [31:0] opmode_word;
	logic [31:0] cap_word;
	logic [31:0] id_word;
	logic [31:0] pin_word;

	// Strap and mode pin synchroniser, free running
	always_ff @(posedge core_clk)
	begin
		sync1 <= {clock_buffer_powerdown_strap, opmode_pins};
		sync2 <= sync1;
		sync3 <= sync2;
	end

	// Filtered strap levels: a bit changes once stages two and three agree
	always_comb
	begin
		for (int i = 0; i < SW; i++)
		begin
			next_straps[i] = (sync2[i] == sync3[i]) ? sync3[i] : straps[i];
		end
	end

	// Filtered strap register, no reset: it keeps settling during reset
	always_ff @(posedge core_clk)
	begin
		straps <= next_straps;
	end

	// Side-loaded fields: SMBus or EEPROM writes only, software cannot touch
	// Master bit follows the filtered strap until the first load of byte 2 of the operation mode register after reset
	// Covers a reset shorter than the strap filter latency
	always_comb
	begin
		next_cbuf = cbuf;
		next_subsystem_vendor_identifier = subsystem_vendor_identifier;
		next_subsystem_device_identifier = subsystem_device_identifier;
		next_strap_owned = strap_owned;
		if (strap_owned)
		begin
			next_cbuf[`SCGR_CBUF_MASTER] = straps[SW-1];
		end
		if (load_valid && load_req.write)
		begin
			if (load_req.addr == `SCGR_OFS_OPMODE && load_req.be[2])
			begin
				// Bit 19 is stored and read back, with no function
				next_cbuf = load_req.data[`SCGR_CBUF_LSB +: `SCGR_CBUF_W];
				next_strap_owned = 1'b0;
			end
			if (load_req.addr == `SCGR_OFS_SUBSYSTEM_DEVICE_IDENTIFIER)
			begin
				if (load_req.be[0])
					next_subsystem_vendor_identifier[7:0] = load_req.data[7:0];
				if (load_req.be[1])
					next_subsystem_vendor_identifier[15:8] = load_req.data[15:8];
				if (load_req.be[2])
					next_subsystem_device_identifier[7:0] = load_req.data[23:16];
				if (load_req.be[3])
					next_subsystem_device_identifier[15:8] = load_req.data[31:24];
			end
		end
		// Master disable overrides the per-pair enables
		next_refclk = next_cbuf[`SCGR_CBUF_MASTER] ? '0 : next_cbuf[`SCGR_CBUF_PAIRS-1:0];
	end

	// Side-loaded state and clock pair enables
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cbuf <= {straps[SW-1], `SCGR_CBUF_LOW_RST};
			strap_owned <= 1'b1;
			subsystem_vendor_identifier <= SUBSYSTEM_VENDOR_IDENTIFIER_RST;
			subsystem_device_identifier <= SUBSYSTEM_DEVICE_IDENTIFIER_RST;
			reference_clock_out_pair <= straps[SW-1] ? '0 : 3'h7;
		end
		else
		begin
			cbuf <= next_cbuf;
			strap_owned <= next_strap_owned;
			subsystem_vendor_identifier <= next_subsystem_vendor_identifier;
			subsystem_device_identifier <= next_subsystem_device_identifier;
			reference_clock_out_pair <= next_refclk;
		end
	end

	// Software write to the pin control register, low half only
	assign gpio_wr = cfg_valid && cfg_req.write && (cfg_req.addr == `SCGR_OFS_GPIO);

	// One pin slice per pin, four register bits each
	genvar g;
	generate
		for (g = 0; g < `SCGR_GPIO_PINS; g++)
		begin : pin
			localparam int B = g * `SCGR_GPIO_STRIDE;
			scgr_gpio_pin u_pin
			(
				.core_clk(core_clk),
				.rst_n(rst_n),
				.upstream(upstream),
				.wr_en(gpio_wr && cfg_req.be[B/8]),
				.wr_oe(cfg_req.data[B + `SCGR_GPIO_OE_BIT]),
				.wr_out(cfg_req.data[B + `SCGR_GPIO_OUT_BIT]),
				.pin_in(gpio_in[g]),
				.pin_out(gpio_out[g]),
				.pin_oe(gpio_oe[g]),
				.field(gpio_word[B +: `SCGR_GPIO_STRIDE])
			);
		end
	endgenerate

	// Register words, assembled once for the read mux
	assign opmode_word = {11'h0, cbuf, 7'h0, straps[SW-2:0]};
	assign cap_word = {16'h0, `SCGR_CAP_NEXT, `SCGR_CAP_ID};
	assign id_word = {subsystem_device_identifier, subsystem_vendor_identifier};
	assign pin_word = upstream ? {16'h0, gpio_word} : 32'h0;

	// Read mux; writes to read-only registers are dropped
	always_comb
	begin
		next_ack = cfg_valid;
		next_rdata = cfg_rdata;
		if (cfg_valid)
		begin
			next_rdata = 32'h0;
			if (!cfg_req.write)
			begin
				unique case (cfg_req.addr)
					`SCGR_OFS_OPMODE:
						next_rdata = opmode_word;
					`SCGR_OFS_SSCAP:
						next_rdata = cap_word;
					`SCGR_OFS_SUBSYSTEM_DEVICE_IDENTIFIER:
						next_rdata = id_word;
					`SCGR_OFS_GPIO:
						next_rdata = pin_word;
					default:
						next_rdata = 32'h0;
				endcase
			end
		end
	end

	// Answer registered one cycle after the request
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h0;
		end
		else
		begin
			cfg_ack <= next_ack;
			cfg_rdata <= next_rdata;
		end
	end

endmodule // scgr_regs

// ==== scgr_cfg.svh ====
`ifndef SCGR_CFG_SVH
`define SCGR_CFG_SVH

// Register byte offsets
`define SCGR_OFS_OPMODE 8'h98
`define SCGR_OFS_SSCAP 8'hB0
`define SCGR_OFS_SUBSYSTEM_DEVICE_IDENTIFIER 8'hB4
`define SCGR_OFS_GPIO 8'hB8

// Operation mode / clock buffer field positions
`define SCGR_OPMODE_LSB 0
`define SCGR_OPMODE_W 9
`define SCGR_CBUF_LSB 16
`define SCGR_CBUF_W 5
`define SCGR_CBUF_MASTER 4
`define SCGR_CBUF_RSVD 3
`define SCGR_CBUF_PAIRS 3
`define SCGR_CBUF_LOW_RST 4'hF

// Capability header constants
`define SCGR_CAP_ID 8'h0D
`define SCGR_CAP_NEXT 8'hC0

// Subsystem identifier positions
`define SCGR_SUBSYSTEM_VENDOR_IDENTIFIER_LSB 0
`define SCGR_SUBSYSTEM_DEVICE_IDENTIFIER_LSB 16

// General-purpose pin layout, four bits per pin
`define SCGR_GPIO_PINS 4
`define SCGR_GPIO_STRIDE 4
`define SCGR_GPIO_IN_BIT 0
`define SCGR_GPIO_OE_BIT 1
`define SCGR_GPIO_OUT_BIT 2
`define SCGR_GPIO_OE_RST 1'b0
`define SCGR_GPIO_OUT_RST 1'b0

`endif

// ==== scgr_pkg.sv ====
package scgr_pkg;

	// One configuration access: byte address, lanes and data
	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] data;
	} scgr_access_s;

	// Operation mode indications, in register order from bit 8 down to 0
	typedef struct packed {
		logic scan;
		logic [2:0] package_select;
		logic indication_a;
		logic debug;
		logic fast;
		logic quiescent_current_test_n;
		logic serial_rom_bypass;
	} scgr_opmode_s;

endpackage

// ==== scgr_gpio_pin.sv ====
`timescale 1ns/1ps
`include "scgr_cfg.svh"

module scgr_gpio_pin
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic upstream,
	input wire logic wr_en,
	input wire logic wr_oe,
	input wire logic wr_out,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic [3:0] field
);

	logic sync1;
	logic sync2;
	logic sync3;
	logic level;
	logic next_level;
	logic oe;
	logic next_oe;
	logic out;
	logic next_out;

	// Three-stage pin synchroniser, free running
	always_ff @(posedge core_clk)
	begin
		sync1 <= pin_in;
		sync2 <= sync1;
		sync3 <= sync2;
	end

	// Next values of pin state and control bits
	always_comb
	begin
		next_level = (sync2 == sync3) ? sync3 : level;
		next_oe = oe;
		next_out = out;
		if (wr_en && upstream)
		begin
			next_oe = wr_oe;
			next_out = wr_out;
		end
	end

	always_ff @(posedge core_clk)
	begin
		level <= next_level;
		if (!rst_n)
		begin
			oe <= `SCGR_GPIO_OE_RST;
			out <= `SCGR_GPIO_OUT_RST;
		end
		else
		begin
			oe <= next_oe;
			out <= next_out;
		end
	end

	// Pin drive only while enabled on the upstream port
	assign pin_out = out;
	assign pin_oe = oe & upstream;
	assign field = {1'b0, out, oe, level};

endmodule // scgr_gpio_pin

// ==== scgr_regs_assertions.sv ====
`timescale 1ns/1ps
module scgr_regs_assertions
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic upstream,
	input wire logic cfg_valid,
	input wire scgr_pkg::scgr_access_s cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic load_valid,
	input wire scgr_pkg::scgr_access_s load_req,
	input wire logic [2:0] reference_clock_out_pair,
	input wire logic [3:0] gpio_out,
	input wire logic [3:0] gpio_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic cl;
	logic gw;
	// Buffer side-load and pin register write
	assign cl = load_valid && load_req.write && load_req.addr == 8'h98 && load_req.be[2];
	assign gw = cfg_valid && cfg_req.write && cfg_req.addr == 8'hB8 && upstream;
	a_cap_value: assert property (cfg_valid && !cfg_req.write && cfg_req.addr == 8'hB0
		|=> cfg_rdata == 32'h0000C00D) else $error("cap");
	a_master_off: assert property (cl && load_req.data[20] |=> !reference_clock_out_pair)
		else $error("master");
	a_pair_gate: assert property (cl && !load_req.data[20]
		|=> reference_clock_out_pair == $past(load_req.data[18:16])) else $error("pair");
	a_buf_stable: assert property (!load_valid && cfg_valid && cfg_req.write
		|=> $stable(reference_clock_out_pair)) else $error("buf");
	a_pins_low: assert property (gw && cfg_req.be[0]
		|=> gpio_out[1:0] == {$past(cfg_req.data[6]), $past(cfg_req.data[2])}) else $error("out");
	a_pin_three: assert property (gw && cfg_req.be[1] |=> gpio_out[3] == $past(cfg_req.data[14]))
		else $error("pin3");
	a_oe_write: assert property (gw && cfg_req.be[1]
		|=> gpio_oe[3:2] == {$past(cfg_req.data[13]), $past(cfg_req.data[9])}) else $error("oe");
	a_oe_upstream: assert property (!upstream |-> gpio_oe == 4'h0) else $error("up");
endmodule // scgr_regs_assertions

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench;
	logic core_clk = 0, rst_n = 0, upstream = 1, cfg_valid = 0, load_valid = 0, strap = 1;
	logic cfg_ack;
	scgr_pkg::scgr_access_s cfg_req = '0, load_req = '0;
	scgr_pkg::scgr_opmode_s opm = '0;
	logic [31:0] cfg_rdata, rd, v;
	logic [2:0] pairs;
	logic [3:0] gpio_in = 0, gpio_out, gpio_oe, oe, ov;
	logic [4:0] cb;
	int n_errors = 0, check_count = 0, seed = 80444, i;
	// Clock
	always #4 core_clk = ~core_clk;
	scgr_regs dut (.core_clk, .rst_n, .upstream, .cfg_valid, .cfg_req, .cfg_ack, .cfg_rdata,
		.load_valid, .load_req, .opmode_pins(opm), .clock_buffer_powerdown_strap(strap),
		.reference_clock_out_pair(pairs), .gpio_in, .gpio_out, .gpio_oe);
	task automatic chk(input logic [31:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(negedge core_clk);
		cfg_valid = 1;
		cfg_req = '{w, a, be, d};
		@(negedge core_clk);
		cfg_valid = 0;
		rd = cfg_rdata;
		chk(cfg_ack, 1);
	endtask
	task automatic ld(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge core_clk);
		load_valid = 1;
		load_req = '{1'b1, a, be, d};
		@(negedge core_clk);
		load_valid = 0;
	endtask
	task automatic rst();
		rst_n = 0;
		repeat (3) @(negedge core_clk);
		rst_n = 1;
		oe = 0;
		ov = 0;
		cb = {strap, 4'hF};
		// Strap filter settles two cycles after a short reset
		repeat (2) @(negedge core_clk);
	endtask
	function automatic logic [31:0] gexp(input logic [3:0] pin);
		gexp = 0;
		for (int k = 0; k < 4; k++)
			gexp[4*k +: 3] = {ov[k], oe[k], pin[k]};
	endfunction
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Watchdog
	initial
	begin
		#100000;
		n_errors++;
		end_of_test();
	end
	// Main sequence
	initial
	begin
		opm = 9'($random(seed));
		rst();
		chk(pairs, 0);
		acc(0, 8'h98, 4'hF, 0);
		chk(rd, {11'h0, cb, 7'h0, opm});
		acc(1, 8'hB0, 4'hF, '1);
		acc(0, 8'hB0, 4'hF, 0);
		chk(rd, 32'h0000C00D);
		acc(0, 8'hB4, 4'hF, 0);
		chk(rd, 32'h3C5A5A3C);
		v = $random(seed);
		ld(8'hB4, 4'hF, v);
		acc(1, 8'hB4, 4'hF, ~v);
		acc(0, 8'hB4, 4'hF, 0);
		chk(rd, v);
		acc(0, 8'h9C, 4'hF, 0);
		chk(rd, 0);
		$display("ids done");
		for (i = 0; i < 8; i++)
		begin
			v = (i == 0) ? 32'h001F_0000 : (i == 1) ? 32'h0005_0000 : $random(seed);
			ld(8'h98, i == 3 ? 4'h3 : 4'h4, v);
			if (i != 3)
				cb = v[20:16];
			chk(pairs, cb[4] ? 3'h0 : cb[2:0]);
			acc(1, 8'h98, 4'hF, ~v);
			acc(0, 8'h98, 4'hF, 0);
			chk(rd[20:16], cb);
			chk(rd[31:21], 0);
		end
		$display("buffer done");
		for (i = 0; i < 8; i++)
		begin
			v = $random(seed);
			gpio_in = v[31:28];
			acc(1, 8'hB8, 4'h3, v);
			oe = {v[13], v[9], v[5], v[1]};
			ov = {v[14], v[10], v[6], v[2]};
			chk(gpio_oe, oe);
			chk(gpio_out & oe, ov & oe);
			repeat (3) @(negedge core_clk);
			acc(0, 8'hB8, 4'hF, 0);
			chk(rd, gexp(gpio_in));
		end
		upstream = 0;
		acc(1, 8'hB8, 4'h3, '1);
		chk(gpio_oe, 0);
		acc(0, 8'hB8, 4'hF, 0);
		chk(rd, 0);
		upstream = 1;
		acc(0, 8'hB8, 4'hF, 0);
		chk(rd, gexp(gpio_in));
		$display("pins done");
		strap = 0;
		repeat (4) @(negedge core_clk);
		rst();
		chk(gpio_oe | gpio_out, 0);
		chk(pairs, 3'h7);
		acc(0, 8'h98, 4'hF, 0);
		chk(rd[20:16], cb);
		$display("reset done");
		end_of_test();
	end
endmodule // testbench
bind scgr_regs scgr_regs_assertions u_chk (.core_clk, .rst_n, .upstream, .cfg_valid, .cfg_req,
	.cfg_rdata, .load_valid, .load_req, .reference_clock_out_pair, .gpio_out, .gpio_oe);
